// [src/pfs_pin_cell.sv]
// Purpose: One pad cell: registered drive, open-drain gating, input sync
// Assumes: Pad input is asynchronous to clock
// Notes:   Output enable high while the cell drives the pad
`timescale 1ns/1ns
`default_nettype none

module pfs_pin_cell (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic drive_en,
  input  wire logic drive_val,
  input  wire logic open_drain,
  input  wire logic pin_in,
  output var  logic pin_out,
  output var  logic pin_oe,
  output var  logic pin_level
);

  logic sync_first;
  wire  next_oe;
  wire  next_out;

  // ----------------------------------------
  // Drive: open drain never drives high
  // ----------------------------------------
  assign next_oe  = drive_en & ~(open_drain & drive_val);
  assign next_out = drive_val & ~open_drain;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_oe  <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      pin_oe  <= next_oe;
      pin_out <= next_out;
    end
  end

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_first <= 1'b0;
      pin_level  <= 1'b0;
    end else begin
      sync_first <= pin_in;
      pin_level  <= sync_first;
    end
  end

endmodule : pfs_pin_cell

`default_nettype wire

// [src/pfs_pkg.sv]
// Purpose: Constants for the port pin function select block
// Assumes: AXI4-Lite register access, one 125 MHz clock
// Notes:   Pins 0 to 4 of the port only

package pfs_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int NUM_PINS = 5;
  localparam int ADDR_W   = 5;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_DIR      = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_LATCH    = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_PINS     = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_OD       = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h14;

  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [NUM_PINS-1:0] RST_DIR   = 5'h00;
  localparam logic [NUM_PINS-1:0] RST_LATCH = 5'h00;
  localparam logic [NUM_PINS-1:0] RST_OD    = 5'h00;
  localparam logic                RST_STAT  = 1'h0;
  localparam logic                RST_MASK  = 1'h0;
  localparam int                  PIN_TX0   = 0;
  localparam int                  PIN_TX1   = 1;
  localparam int                  PIN_RX0   = 2;
  localparam int                  PIN_RX1   = 3;
  localparam int                  PIN_CLK   = 4;

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : pfs_pkg

// [src/pfs_port_mux.sv]
// Purpose: Port pin function select with AXI4-Lite port registers
// Assumes: Serial channel controls come from logic on the same clock
// Notes:   Interrupt status clears on read; set wins over clear
`timescale 1ns/1ns
`default_nettype none

module pfs_port_mux #(
  parameter int NUM_PINS = pfs_pkg::NUM_PINS
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic [pfs_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output var  logic                        s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output var  logic                        s_axi_wready,
  output var  logic [1:0]                  s_axi_bresp,
  output var  logic                        s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [pfs_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output var  logic                        s_axi_arready,
  output var  logic [31:0]                 s_axi_rdata,
  output var  logic [1:0]                  s_axi_rresp,
  output var  logic                        s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        serial0_sync_mode,
  input  wire logic                        serial_clock_enable_low,
  input  wire logic                        serial_clock_enable_high,
  input  wire logic                        serial0_rx_on,
  input  wire logic                        serial0_tx_on,
  input  wire logic                        serial1_rx_on,
  input  wire logic                        serial1_tx_on,
  input  wire logic                        serial0_tx_data,
  input  wire logic                        serial1_tx_data,
  input  wire logic                        serial0_clock_out,
  output var  logic                        serial0_rx_data,
  output var  logic                        serial1_rx_data,
  output var  logic                        serial0_clock_in,
  output var  logic                        external_interrupt_line_4,
  input  wire logic [NUM_PINS-1:0]         pin_in,
  output var  logic [NUM_PINS-1:0]         pin_out,
  output var  logic [NUM_PINS-1:0]         pin_oe,
  output var  logic                        irq
);

  if (NUM_PINS != 5) begin : g_check
    $error("pfs_port_mux serves exactly five pins");
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic addr_hit(input logic [pfs_pkg::ADDR_W-1:0] addr,
                                    input logic [pfs_pkg::ADDR_W-1:0] off);
    addr_hit = (addr == off);
  endfunction : addr_hit

  function automatic logic addr_mapped(input logic [pfs_pkg::ADDR_W-1:0] addr);
    addr_mapped = addr_hit(addr, pfs_pkg::OFF_DIR) | addr_hit(addr, pfs_pkg::OFF_LATCH) |
                  addr_hit(addr, pfs_pkg::OFF_PINS) | addr_hit(addr, pfs_pkg::OFF_OD) |
                  addr_hit(addr, pfs_pkg::OFF_IRQ_STAT) | addr_hit(addr, pfs_pkg::OFF_IRQ_MASK);
  endfunction : addr_mapped

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [NUM_PINS-1:0]        port_direction_reg;
  logic [NUM_PINS-1:0]        port_output_latch;
  logic [NUM_PINS-1:0]        port_opendrain_reg;
  logic [NUM_PINS-1:0]        pin_level;
  logic                       irq_status;
  logic                       irq_mask;
  logic                       external_interrupt_line_4_level_d;
  logic                       aw_held;
  logic                       w_held;
  logic [pfs_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0]                 wr_data;
  logic                       wr_lane0;

  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_en    = do_write & wr_lane0 & addr_mapped(wr_addr);

  wire wr_dir   = wr_en & addr_hit(wr_addr, pfs_pkg::OFF_DIR);
  wire wr_latch = wr_en & addr_hit(wr_addr, pfs_pkg::OFF_LATCH);
  wire wr_od    = wr_en & addr_hit(wr_addr, pfs_pkg::OFF_OD);
  wire wr_mask  = wr_en & addr_hit(wr_addr, pfs_pkg::OFF_IRQ_MASK);
  wire rd_stat  = ar_take & addr_hit(s_axi_araddr, pfs_pkg::OFF_IRQ_STAT);

  // ----------------------------------------
  // Pin function selection
  // ----------------------------------------
  wire clk_drive = ~serial_clock_enable_high &
                   (serial0_sync_mode | serial_clock_enable_low);
  wire [NUM_PINS-1:0] serial_out_sel;
  wire [NUM_PINS-1:0] serial_in_sel;
  wire [NUM_PINS-1:0] serial_val;
  wire [NUM_PINS-1:0] drive_en;
  wire [NUM_PINS-1:0] drive_val;

  assign serial_out_sel[pfs_pkg::PIN_TX0] = serial0_tx_on;
  assign serial_out_sel[pfs_pkg::PIN_TX1] = serial1_tx_on;
  assign serial_out_sel[pfs_pkg::PIN_RX0] = 1'b0;
  assign serial_out_sel[pfs_pkg::PIN_RX1] = 1'b0;
  assign serial_out_sel[pfs_pkg::PIN_CLK] = clk_drive;
  assign serial_in_sel[pfs_pkg::PIN_TX0]  = 1'b0;
  assign serial_in_sel[pfs_pkg::PIN_TX1]  = 1'b0;
  assign serial_in_sel[pfs_pkg::PIN_RX0]  = serial0_rx_on;
  assign serial_in_sel[pfs_pkg::PIN_RX1]  = serial1_rx_on;
  assign serial_in_sel[pfs_pkg::PIN_CLK]  = serial_clock_enable_high;
  assign serial_val[pfs_pkg::PIN_TX0]     = serial0_tx_data;
  assign serial_val[pfs_pkg::PIN_TX1]     = serial1_tx_data;
  assign serial_val[pfs_pkg::PIN_RX0]     = 1'b0;
  assign serial_val[pfs_pkg::PIN_RX1]     = 1'b0;
  assign serial_val[pfs_pkg::PIN_CLK]     = serial0_clock_out;

  genvar gi;
  for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
    assign drive_en[gi]  = ~serial_in_sel[gi] &
                           (serial_out_sel[gi] | port_direction_reg[gi]);
    assign drive_val[gi] = serial_out_sel[gi] ? serial_val[gi] : port_output_latch[gi];

    pfs_pin_cell u_cell (
      .clock      (clock),
      .rst_n      (rst_n),
      .drive_en   (drive_en[gi]),
      .drive_val  (drive_val[gi]),
      .open_drain (port_opendrain_reg[gi]),
      .pin_in     (pin_in[gi]),
      .pin_out    (pin_out[gi]),
      .pin_oe     (pin_oe[gi]),
      .pin_level  (pin_level[gi])
    );
  end

  // Inputs to serial channels and interrupt line
  assign serial0_rx_data           = pin_level[pfs_pkg::PIN_RX0];
  assign serial1_rx_data           = pin_level[pfs_pkg::PIN_RX1];
  assign serial0_clock_in          = pin_level[pfs_pkg::PIN_CLK];
  assign external_interrupt_line_4 = pin_level[pfs_pkg::PIN_CLK];

  // ----------------------------------------
  // Port registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_direction_reg <= pfs_pkg::RST_DIR;
      port_output_latch  <= pfs_pkg::RST_LATCH;
      port_opendrain_reg <= pfs_pkg::RST_OD;
      irq_mask           <= pfs_pkg::RST_MASK;
    end else begin
      if (wr_dir)   port_direction_reg <= wr_data[NUM_PINS-1:0];
      if (wr_latch) port_output_latch  <= wr_data[NUM_PINS-1:0];
      if (wr_od)    port_opendrain_reg <= wr_data[NUM_PINS-1:0];
      if (wr_mask)  irq_mask           <= wr_data[0];
    end
  end

  // ----------------------------------------
  // Interrupt: falling edge of line 4
  // ----------------------------------------
  wire external_interrupt_line_4_event  = external_interrupt_line_4_level_d & ~pin_level[pfs_pkg::PIN_CLK];
  wire next_status = external_interrupt_line_4_event | (irq_status & ~rd_stat);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      external_interrupt_line_4_level_d <= 1'b0;
      irq_status   <= pfs_pkg::RST_STAT;
      irq          <= 1'b0;
    end else begin
      external_interrupt_line_4_level_d <= pin_level[pfs_pkg::PIN_CLK];
      irq_status   <= next_status;
      irq          <= next_status & irq_mask;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= '0;
      wr_data       <= 8'h00;
      wr_lane0      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pfs_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held       <= 1'b1;
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held       <= 1'b1;
        wr_data      <= s_axi_wdata[7:0];
        wr_lane0     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_mapped(wr_addr) ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  wire [NUM_PINS-1:0] pin_read = (port_direction_reg & port_output_latch) |
                                 (~port_direction_reg & pin_level);
  wire [31:0] rd_mux =
    addr_hit(s_axi_araddr, pfs_pkg::OFF_LATCH)    ? {27'h0, port_output_latch}  :
    addr_hit(s_axi_araddr, pfs_pkg::OFF_PINS)     ? {27'h0, pin_read}           :
    addr_hit(s_axi_araddr, pfs_pkg::OFF_OD)       ? {27'h0, port_opendrain_reg} :
    addr_hit(s_axi_araddr, pfs_pkg::OFF_IRQ_STAT) ? {31'h0, irq_status}         :
    addr_hit(s_axi_araddr, pfs_pkg::OFF_IRQ_MASK) ? {31'h0, irq_mask}           :
    32'h0;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= pfs_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= addr_mapped(s_axi_araddr) ? pfs_pkg::RESP_OKAY : pfs_pkg::RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence clk_drive_req;
    clk_drive && !port_opendrain_reg[pfs_pkg::PIN_CLK];
  endsequence

  sequence pins_read_req;
    ar_take && addr_hit(s_axi_araddr, pfs_pkg::OFF_PINS);
  endsequence

  pin4_clk_out_a: assert property (clk_drive_req |=> pin_oe[pfs_pkg::PIN_CLK] &&
      pin_out[pfs_pkg::PIN_CLK] == $past(serial0_clock_out))
    else $error("Pin 4 not driving serial clock");
  pin4_clk_in_a: assert property (serial_clock_enable_high |=> !pin_oe[pfs_pkg::PIN_CLK])
    else $error("Pin 4 driven while clock input selected");
  od_no_high_a: assert property (pin_oe[pfs_pkg::PIN_CLK] && pin_out[pfs_pkg::PIN_CLK]
      |-> !$past(port_opendrain_reg[pfs_pkg::PIN_CLK]))
    else $error("Open-drain pin 4 driven high");
  external_interrupt_line_4_follow_a: assert property ($fell(external_interrupt_line_4) |=> irq_status)
    else $error("Interrupt line 4 edge not latched");
  rx1_input_a: assert property (serial1_rx_on |=> !pin_oe[pfs_pkg::PIN_RX1])
    else $error("Pin 3 driven while receiving");
  rx0_input_a: assert property (serial0_rx_on |=> !pin_oe[pfs_pkg::PIN_RX0])
    else $error("Pin 2 driven while receiving");
  tx1_drive_a: assert property (serial1_tx_on && !port_opendrain_reg[pfs_pkg::PIN_TX1]
      |=> pin_oe[pfs_pkg::PIN_TX1] && pin_out[pfs_pkg::PIN_TX1] == $past(serial1_tx_data))
    else $error("Pin 1 not driving transmit data");
  tx0_drive_a: assert property (serial0_tx_on && !port_opendrain_reg[pfs_pkg::PIN_TX0]
      |=> pin_oe[pfs_pkg::PIN_TX0] && pin_out[pfs_pkg::PIN_TX0] == $past(serial0_tx_data))
    else $error("Pin 0 not driving transmit data");
  dir_output_a: assert property (!serial0_tx_on && !port_opendrain_reg[pfs_pkg::PIN_TX0]
      && port_direction_reg[pfs_pkg::PIN_TX0] |=> pin_oe[pfs_pkg::PIN_TX0])
    else $error("Direction bit did not enable output");
  pin_read_a: assert property (pins_read_req |=> s_axi_rvalid &&
      s_axi_rdata[NUM_PINS-1:0] == (($past(port_direction_reg) & $past(port_output_latch)) |
      (~$past(port_direction_reg) & $past(pin_level))))
    else $error("Pin register read mismatch");
  od_push_pull_a: assert property (!port_opendrain_reg[pfs_pkg::PIN_TX1] &&
      drive_en[pfs_pkg::PIN_TX1] && drive_val[pfs_pkg::PIN_TX1]
      |=> pin_oe[pfs_pkg::PIN_TX1] && pin_out[pfs_pkg::PIN_TX1])
    else $error("Push-pull pin did not drive high");

  sequence stat_read_req;
    rd_stat && !external_interrupt_line_4_event;
  endsequence

  sequence dir_read_req;
    ar_take && addr_hit(s_axi_araddr, pfs_pkg::OFF_DIR);
  endsequence

  sequence pin4_port_req;
    !serial_clock_enable_high && !clk_drive && port_direction_reg[pfs_pkg::PIN_CLK] &&
    !port_opendrain_reg[pfs_pkg::PIN_CLK];
  endsequence

  sequence tx1_low_od_req;
    serial1_tx_on && port_opendrain_reg[pfs_pkg::PIN_TX1] && !serial1_tx_data;
  endsequence

  irq_cause_a: assert property (irq |-> irq_status)
    else $error("Interrupt raised without status");
  irq_raise_a: assert property (irq_status && $past(irq_mask) |-> irq)
    else $error("Unmasked status without interrupt");
  stat_clear_a: assert property (stat_read_req |=> !irq_status)
    else $error("Status not cleared by read");
  mask_land_a: assert property (wr_mask |=>
      irq_mask == $past(wr_data[0]))
    else $error("Mask write lost");
  dir_wo_a: assert property (dir_read_req |=> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("Direction register readable");
  dir_land_a: assert property (wr_dir |=>
      port_direction_reg == $past(wr_data[NUM_PINS-1:0]))
    else $error("Direction write lost");
  latch_land_a: assert property (wr_latch |=>
      port_output_latch == $past(wr_data[NUM_PINS-1:0]))
    else $error("Output latch write lost");
  od_land_a: assert property (wr_od |=>
      port_opendrain_reg == $past(wr_data[NUM_PINS-1:0]))
    else $error("Open-drain write lost");
  dir_input_a: assert property (!serial1_tx_on && !port_direction_reg[pfs_pkg::PIN_TX1]
      |=> !pin_oe[pfs_pkg::PIN_TX1])
    else $error("Pin 1 driven while input");
  pin4_port_a: assert property (pin4_port_req |=> pin_oe[pfs_pkg::PIN_CLK] &&
      pin_out[pfs_pkg::PIN_CLK] == $past(port_output_latch[pfs_pkg::PIN_CLK]))
    else $error("Pin 4 not acting as port output");
  tx1_od_low_a: assert property (tx1_low_od_req |=> pin_oe[pfs_pkg::PIN_TX1] &&
      !pin_out[pfs_pkg::PIN_TX1])
    else $error("Open-drain transmit low not driven");
  od_never_high_a: assert property (
      !(|(pin_oe & pin_out & $past(port_opendrain_reg))))
    else $error("Open-drain pin driven high");

endmodule : pfs_port_mux

`default_nettype wire

// [tb/pfs_board_model.sv]
// Purpose: Board side of the port pins, with a pull-up on every pad
// Assumes: Bench selects which pads the board drives and with what value
// Notes:   Pad level resolves from both parties' enables
`timescale 1ns/1ns
`default_nettype none

module pfs_board_model (
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  input  wire logic [4:0] ext_en,
  input  wire logic [4:0] ext_val,
  output var  logic [4:0] pin_in
);
  // ----------------------------------------
  // Pad resolution
  // ----------------------------------------
  // Cell drive wins; a released pad takes the board value where the board drives it, else floats to the pull-up
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'h1);
    end
  end
endmodule : pfs_board_model

`default_nettype wire

// [tb/port3_pin_function_select_test.sv]
// Purpose: Register and pin function checks of the port mux
// Assumes: AXI4-Lite master tasks, board model with pull-ups
// Notes:   Pins settle 3 cycles after a register write
`timescale 1ns/1ns
`default_nettype none

module port3_pin_function_select_test;
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp, rs;
  logic        sync = 1'h0, ckl = 1'h0, ckh = 1'h0, rx0 = 1'h0, rx1 = 1'h0;
  logic        tx0 = 1'h0, tx1 = 1'h0, serial0_tx_pin = 1'h0, serial1_tx_pin = 1'h0, cko = 1'h0;
  logic        serial0_rx_pin, serial1_rx_pin, cki, ext_irq, ck_out;
  logic [4:0]  ext_en = 5'h00, ext_val = 5'h00, pin_in, pin_out, pin_oe;
  int          num_errors = 0;
  int          comparisons = 0;

  initial forever #4 clock = ~clock;

  pfs_port_mux dut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .serial0_sync_mode(sync), .serial_clock_enable_low(ckl),
    .serial_clock_enable_high(ckh), .serial0_rx_on(rx0), .serial0_tx_on(tx0),
    .serial1_rx_on(rx1), .serial1_tx_on(tx1), .serial0_tx_data(serial0_tx_pin),
    .serial1_tx_data(serial1_tx_pin), .serial0_clock_out(cko), .serial0_rx_data(serial0_rx_pin),
    .serial1_rx_data(serial1_rx_pin), .serial0_clock_in(cki), .external_interrupt_line_4(ext_irq),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

  pfs_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!got) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        got = 1;
        r = bresp;
        bready <= 1'h0;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    bit got;
    got = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!got) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        got = 1;
        d = rdata;
        r = rresp;
        rready <= 1'h0;
      end
    end
  endtask : axi_rd

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, pfs_pkg::RESP_OKAY});
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    axi_rd(a, rd, rs);
    chk(rd, e);
  endtask : rd_chk

  initial begin
    #100000;
    num_errors++;
    end_of_test;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    wt(3);
    rst_n <= 1'h1;
    wt(1);
    rd_chk(pfs_pkg::OFF_DIR, 32'h0);
    rd_chk(pfs_pkg::OFF_OD, 32'h0);
    rd_chk(pfs_pkg::OFF_LATCH, 32'h0);
    axi_rd(5'h18, rd, rs);
    chk({30'h0, rs}, {30'h0, pfs_pkg::RESP_DECERR});
    axi_wr(5'h1c, 32'h1f, rs);
    chk({30'h0, rs}, {30'h0, pfs_pkg::RESP_DECERR});
    // Mixed directions and pin readback
    wr(pfs_pkg::OFF_DIR, 32'h0a);
    wr(pfs_pkg::OFF_LATCH, 32'h0a);
    ext_en <= 5'h15;
    ext_val <= 5'h11;
    wt(4);
    chk({27'h0, pin_oe}, 32'h0a);
    chk({27'h0, pin_out & pin_oe}, 32'h0a);
    rd_chk(pfs_pkg::OFF_DIR, 32'h0);
    rd_chk(pfs_pkg::OFF_PINS, 32'h1b);
    // Open drain on port and transmit pins
    ext_en <= 5'h00;
    wr(pfs_pkg::OFF_DIR, 32'h03);
    wr(pfs_pkg::OFF_LATCH, 32'h01);
    wr(pfs_pkg::OFF_OD, 32'h03);
    wt(3);
    chk({30'h0, pin_oe[1:0]}, 32'h2);
    chk({30'h0, pin_out[1:0]}, 32'h0);
    tx0 <= 1'h1;
    tx1 <= 1'h1;
    serial0_tx_pin <= 1'h1;
    wr(pfs_pkg::OFF_DIR, 32'h00);
    wt(3);
    chk({30'h0, pin_oe[1:0]}, 32'h2);
    wr(pfs_pkg::OFF_OD, 32'h00);
    rd_chk(pfs_pkg::OFF_OD, 32'h0);
    wt(3);
    chk({30'h0, pin_oe[1:0]}, 32'h3);
    chk({30'h0, pin_out[1:0]}, 32'h1);
    tx0 <= 1'h0;
    tx1 <= 1'h0;
    // Receive pins stay inputs whatever the direction bits say
    rx0 <= 1'h1;
    rx1 <= 1'h1;
    wr(pfs_pkg::OFF_DIR, 32'h0c);
    ext_en <= 5'h0c;
    ext_val <= 5'h08;
    wt(4);
    chk({30'h0, pin_oe[3:2]}, 32'h0);
    chk({30'h0, serial1_rx_pin, serial0_rx_pin}, 32'h2);
    rx0 <= 1'h0;
    rx1 <= 1'h0;
    ext_en <= 5'h00;
    ext_val <= 5'h00;
    // Pin 4 function over all selector combinations
    cko <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      ckh <= i[2];
      sync <= i[1];
      ckl <= i[0];
      ext_en <= {i[2], 4'h0};
      wr(pfs_pkg::OFF_DIR, {27'h0, i[3], 4'h0});
      wt(4);
      ck_out = !i[2] && (i[1] || i[0]);
      chk({31'h0, pin_oe[4]}, {31'h0, !i[2] && (ck_out || i[3])});
      if (ck_out) chk({31'h0, pin_out[4]}, 32'h1);
      if (i[2]) chk({31'h0, cki}, 32'h0);
    end
    ckh <= 1'h0;
    sync <= 1'h0;
    ckl <= 1'h0;
    wr(pfs_pkg::OFF_DIR, 32'h00);
    // Interrupt line, masked and unmasked; pin 4 fell during the loop
    rd_chk(pfs_pkg::OFF_IRQ_STAT, 32'h1);
    wr(pfs_pkg::OFF_IRQ_MASK, 32'h1);
    ext_en <= 5'h10;
    ext_val <= 5'h10;
    wt(4);
    chk({31'h0, ext_irq}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    ext_val <= 5'h00;
    wt(4);
    chk({31'h0, irq}, 32'h1);
    rd_chk(pfs_pkg::OFF_IRQ_STAT, 32'h1);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    rd_chk(pfs_pkg::OFF_IRQ_STAT, 32'h0);
    wr(pfs_pkg::OFF_IRQ_MASK, 32'h0);
    ext_val <= 5'h10;
    wt(4);
    ext_val <= 5'h00;
    wt(4);
    chk({31'h0, irq}, 32'h0);
    rd_chk(pfs_pkg::OFF_IRQ_STAT, 32'h1);
    end_of_test;
  end
endmodule : port3_pin_function_select_test

`default_nettype wire
